/* logic/hub_strap_config_latch.sv */
`timescale 1ns/100ps
`default_nettype none
`include "hscl_map.svh"

module hub_strap_config_latch (
   // clock, reset, enable
   input  wire logic                           clk,
   input  wire logic                           reset,
   input  wire logic                           en,
   // apb slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [11:0]                    paddr,
   input  wire logic [31:0]                    pwdata,
   output var  logic [31:0]                    prdata,
   output var  logic                           pready,
   output var  logic                           pslverr,
   // strap pins and external reset pin
   input  wire logic                           extResetN,
   input  wire logic [5:0]                     portDplusDisableStrap,
   input  wire logic [5:0]                     portDminusDisableStrap,
   input  wire logic [2:0]                     fixedPortsSelectStrap,
   input  wire logic [2:0]                     chargingPortsSelectStrap,
   input  wire logic [1:0]                     layoutStrap,
   // decoded configuration
   output var  hscl_pkg::hscl_cfg_s            hubCfg,
   output var  logic [`HSCL_FUNC_PINS-1:0]     funcPinAlt
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [`HSCL_SYNC_W-1:0] rawIn;
   logic [`HSCL_SYNC_W-1:0] sync1_ff;
   logic [`HSCL_SYNC_W-1:0] sync2_ff;
   logic [`HSCL_SYNC_W-1:0] sync3_ff;
   logic [`HSCL_SYNC_W-1:0] stable_ff;
   logic [5:0]              dPlusS;
   logic [5:0]              dMinusS;
   logic [2:0]              fixedS;
   logic [2:0]              chargeS;
   logic [1:0]              layoutS;
   logic                    extRstS;
   hscl_pkg::hscl_state_e   state_ff;
   hscl_pkg::hscl_state_e   nxt_state;
   logic [2:0]              settleCnt_ff;
   logic                    capture;
   hscl_pkg::hscl_cfg_s     cfg_ff;
   hscl_pkg::hscl_cfg_s     nxt_cfg;
   logic                    rsvd_ff;
   logic                    codeBad_ff;
   logic [2:0]              fixedCode_ff;
   logic [2:0]              chargeCode_ff;
   logic [1:0]              ctrl_ff;
   logic                    layoutEff;
   logic [`HSCL_FUNC_PINS-1:0] funcAlt_ff;
   localparam logic [`HSCL_FUNC_PINS-1:0] funcAltMask = `HSCL_FUNC_ALT_MASK;
   logic [31:0]             prdata_ff;
   logic                    pready_ff;
   logic                    pslverr_ff;
   logic [31:0]             nxt_rdata;
   logic                    addrHit;
   logic                    accessIn;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // the third device-mode strap is not brought in at all
   // third strap ignored
   assign rawIn = {extResetN, layoutStrap, chargingPortsSelectStrap,
                   fixedPortsSelectStrap, portDminusDisableStrap, portDplusDisableStrap};

   // a change counts only once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < `HSCL_SYNC_W; gi = gi + 1) begin : g_sync
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               sync1_ff[gi]  <= 1'b0;
               sync2_ff[gi]  <= 1'b0;
               sync3_ff[gi]  <= 1'b0;
               stable_ff[gi] <= 1'b0;
            end else if (en) begin
               sync1_ff[gi] <= rawIn[gi];
               sync2_ff[gi] <= sync1_ff[gi];
               sync3_ff[gi] <= sync2_ff[gi];
               if (sync2_ff[gi] == sync3_ff[gi]) begin
                  stable_ff[gi] <= sync3_ff[gi];
               end
            end
         end
      end
   endgenerate

   assign dPlusS  = stable_ff[5:0];
   assign dMinusS = stable_ff[11:6];
   assign fixedS  = stable_ff[14:12];
   assign chargeS = stable_ff[17:15];
   assign layoutS = stable_ff[19:18];
   assign extRstS = stable_ff[20];

   // ----------------------------------------
   // capture sequencing
   // ----------------------------------------
   // reset of the stable copy reads as external reset held, so power-on
   // and pin reset share one release path
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         hscl_pkg::HSCL_IN_RESET: begin
            if (extRstS) begin
               nxt_state = hscl_pkg::HSCL_SETTLE;
            end
         end
         hscl_pkg::HSCL_SETTLE: begin
            if (!extRstS) begin
               nxt_state = hscl_pkg::HSCL_IN_RESET;
            end else if (capture) begin
               nxt_state = hscl_pkg::HSCL_HOLD;
            end
         end
         hscl_pkg::HSCL_HOLD: begin
            if (!extRstS) begin
               nxt_state = hscl_pkg::HSCL_IN_RESET;
            end
         end
         default: begin
            nxt_state = hscl_pkg::HSCL_IN_RESET;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff <= hscl_pkg::HSCL_IN_RESET;
      end else if (en) begin
         state_ff <= nxt_state;
      end
   end

   // settle window lets strap levels finish passing the synchronisers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         settleCnt_ff <= 3'h0;
      end else if (en) begin
         if (state_ff != hscl_pkg::HSCL_SETTLE) begin
            settleCnt_ff <= 3'h0;
         end else if (!capture) begin
            settleCnt_ff <= settleCnt_ff + 3'h1;
         end
      end
   end

   assign capture = (state_ff == hscl_pkg::HSCL_SETTLE) && extRstS &&
                    (settleCnt_ff == 3'(`HSCL_SETTLE_CYC - 1));

   // ----------------------------------------
   // strap decode
   // ----------------------------------------
   // six level decode
   function automatic logic [5:0] countMask(input logic [2:0] code);
      case (code)
         hscl_pkg::HSCL_LVL_200K_DN: countMask = 6'h00;
         hscl_pkg::HSCL_LVL_200K_UP: countMask = 6'h01;
         hscl_pkg::HSCL_LVL_10K_DN:  countMask = 6'h03;
         hscl_pkg::HSCL_LVL_10K_UP:  countMask = 6'h07;
         hscl_pkg::HSCL_LVL_10R_DN:  countMask = 6'h0f;
         hscl_pkg::HSCL_LVL_10R_UP:  countMask = 6'h3f;
         default:                    countMask = 6'h00;
      endcase
   endfunction : countMask

   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_cfg.u2Disable  = dPlusS & dMinusS;
      nxt_cfg.ssDisable  = dPlusS & dMinusS;
      nxt_cfg.fixedPorts = countMask(fixedS);
      nxt_cfg.dcpPorts   = countMask(chargeS);
      nxt_cfg.cdpPorts   = countMask(chargeS);
      nxt_cfg.layout     = (layoutS == 2'h1);
      nxt_cfg.valid      = 1'b1;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_ff <= '0;
      end else if (en) begin
         if (capture) begin
            cfg_ff <= nxt_cfg;
         end else if (!extRstS) begin
            cfg_ff.valid <= 1'b0;
         end
      end
   end

   // flags for straps outside the defined levels
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rsvd_ff       <= 1'b0;
         codeBad_ff    <= 1'b0;
         fixedCode_ff  <= 3'h0;
         chargeCode_ff <= 3'h0;
      end else if (en && capture) begin
         rsvd_ff       <= layoutS[1];
         codeBad_ff    <= (fixedS > 3'h5) || (chargeS > 3'h5);
         fixedCode_ff  <= fixedS;
         chargeCode_ff <= chargeS;
      end
   end

   // ----------------------------------------
   // function pin defaults
   // ----------------------------------------
   // software may override the strapped layout for the function pins and the status bit
   assign layoutEff = ctrl_ff[`HSCL_CT_OVR_EN] ? ctrl_ff[`HSCL_CT_OVR_SEL] : cfg_ff.layout;

   // only pins whose function differs between layouts switch
   generate
      for (gi = 0; gi < `HSCL_FUNC_PINS; gi = gi + 1) begin : g_func
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               funcAlt_ff[gi] <= 1'b0;
            end else if (en) begin
               funcAlt_ff[gi] <= layoutEff & funcAltMask[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // one wait state: pready rises in the second access cycle
   assign accessIn = psel && penable && !pready_ff;
   assign addrHit  = (paddr == `HSCL_STATUS_OFS) || (paddr == `HSCL_PORTS_OFS) ||
                     (paddr == `HSCL_CTRL_OFS);

   always_comb begin
      nxt_rdata = 32'h0;
      case (paddr)
         `HSCL_STATUS_OFS: begin
            nxt_rdata[`HSCL_ST_VALID]    = cfg_ff.valid;
            nxt_rdata[`HSCL_ST_LAYOUT]   = layoutEff;
            nxt_rdata[`HSCL_ST_RSVD]     = rsvd_ff;
            nxt_rdata[`HSCL_ST_CODE_BAD] = codeBad_ff;
            nxt_rdata[10:8]              = fixedCode_ff;
            nxt_rdata[14:12]             = chargeCode_ff;
         end
         `HSCL_PORTS_OFS: begin
            nxt_rdata[5:0]                    = cfg_ff.u2Disable;
            nxt_rdata[`HSCL_PO_FIXED +: 6]    = cfg_ff.fixedPorts;
            nxt_rdata[`HSCL_PO_CHARGE +: 6]   = cfg_ff.dcpPorts;
         end
         `HSCL_CTRL_OFS: begin
            nxt_rdata[1:0] = ctrl_ff;
         end
         default: begin
            nxt_rdata = 32'h0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end else if (en) begin
         pready_ff  <= accessIn;
         pslverr_ff <= accessIn && !addrHit;
         if (accessIn && !pwrite) begin
            prdata_ff <= nxt_rdata;
         end
      end
   end

   // writes land on the edge that sees pready high
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_ff <= `HSCL_CTRL_RST;
      end else if (en) begin
         if (psel && penable && pready_ff && pwrite && (paddr == `HSCL_CTRL_OFS)) begin
            ctrl_ff <= pwdata[1:0];
         end
      end
   end

   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign hubCfg     = cfg_ff;
   assign funcPinAlt = funcAlt_ff;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || !en);

   sequence seqRelease;
      $rose(extRstS);
   endsequence

   sequence seqCaptured;
      ##[1:8] capture ##1 hubCfg.valid;
   endsequence

   capture_release_a: assert property (seqRelease |-> seqCaptured)
      else $error("no capture after reset release");

   port_dis_and_a: assert property (capture |=> hubCfg.u2Disable == $past(dPlusS & dMinusS))
      else $error("port disable not the and of both straps");

   ss_follow_a: assert property (capture |=> hubCfg.ssDisable == $past(dPlusS & dMinusS))
      else $error("superspeed disable differs from usb2 disable");

   fixed_all_a: assert property (capture && fixedS == 3'h5 |=> hubCfg.fixedPorts == 6'h3f)
      else $error("top level did not fix all six ports");

   charge_none_a: assert property (capture && chargeS == 3'h0 |=> hubCfg.dcpPorts == 6'h00)
      else $error("lowest level enabled charging");

   charge_pair_a: assert property (capture && chargeS == 3'h2 |=> hubCfg.dcpPorts == 6'h03 &&
                                   hubCfg.cdpPorts == 6'h03)
      else $error("dedicated and downstream charging differ");

   layout_sel_a: assert property (capture && layoutS == 2'h1 |=> hubCfg.layout)
      else $error("layout 2 not selected");

   func_mask_a: assert property (##1 funcPinAlt == ($past(layoutEff) ? `HSCL_FUNC_ALT_MASK
                                 : 29'h0))
      else $error("function pin defaults wrong");

   cfg_hold_a: assert property (state_ff == hscl_pkg::HSCL_HOLD && !capture
                                |=> $stable(hubCfg) || !extRstS)
      else $error("configuration changed while held");

   ovr_layout_a: assert property (ctrl_ff[`HSCL_CT_OVR_EN] |=> funcPinAlt[4] ==
                                  $past(ctrl_ff[`HSCL_CT_OVR_SEL]))
      else $error("override did not steer layout");

endmodule : hub_strap_config_latch
`default_nettype wire

/* shared/hscl_map.svh */
`ifndef HSCL_MAP_SVH
`define HSCL_MAP_SVH

`define HSCL_PORTS          6
`define HSCL_FUNC_PINS      29
`define HSCL_SYNC_W         21
`define HSCL_FUNC_ALT_MASK  29'h3810190

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define HSCL_STATUS_OFS     12'h000
`define HSCL_PORTS_OFS      12'h004
`define HSCL_CTRL_OFS       12'h008
`define HSCL_CTRL_RST       2'h0
`define HSCL_ST_VALID       0
`define HSCL_ST_LAYOUT      1
`define HSCL_ST_RSVD        2
`define HSCL_ST_CODE_BAD    3
`define HSCL_PO_FIXED       8
`define HSCL_PO_CHARGE      16
`define HSCL_CT_OVR_EN      0
`define HSCL_CT_OVR_SEL     1

// ----------------------------------------
// timing
// ----------------------------------------
`define HSCL_CLK_NS         10
`define HSCL_SETTLE_NS      40
`define HSCL_SETTLE_CYC     ((`HSCL_SETTLE_NS + `HSCL_CLK_NS - 1) / `HSCL_CLK_NS)

`endif

/* shared/hscl_pkg.sv */
`default_nettype none
package hscl_pkg;

   // ----------------------------------------
   // resistor level codes from the sense front end
   // ----------------------------------------
   typedef enum logic [2:0] {
      HSCL_LVL_200K_DN,
      HSCL_LVL_200K_UP,
      HSCL_LVL_10K_DN,
      HSCL_LVL_10K_UP,
      HSCL_LVL_10R_DN,
      HSCL_LVL_10R_UP
   } hscl_level_e;

   typedef enum logic [1:0] {
      HSCL_IN_RESET,
      HSCL_SETTLE,
      HSCL_HOLD
   } hscl_state_e;

   typedef struct packed {
      logic       valid;
      logic       layout;
      logic [5:0] cdpPorts;
      logic [5:0] dcpPorts;
      logic [5:0] fixedPorts;
      logic [5:0] ssDisable;
      logic [5:0] u2Disable;
   } hscl_cfg_s;

endpackage : hscl_pkg
`default_nettype wire

/* testbench/hscl_board_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// board strap resistors and reset source
// ----------------------------------------
module hscl_board_model (
   // bench control
   input  wire logic       clk,
   input  wire logic       resetReq,
   input  wire logic       pinsFree,
   input  wire logic [5:0] setDp,
   input  wire logic [5:0] setDm,
   input  wire logic [2:0] setFx,
   input  wire logic [2:0] setCh,
   input  wire logic [1:0] setLy,
   // pins toward the hub
   output logic            extResetN,
   output logic [5:0]      dplusPin,
   output logic [5:0]      dminusPin,
   output logic [2:0]      fixedPin,
   output logic [2:0]      chargePin,
   output logic [1:0]      layoutPin
);
   logic [2:0] lowCnt_ff = 3'h0;
   logic [5:0] toggle_ff = 6'h15;

   always_ff @(posedge clk) begin
      if (resetReq) begin
         lowCnt_ff <= 3'h6;
      end else if (lowCnt_ff != 3'h0) begin
         lowCnt_ff <= lowCnt_ff - 3'h1;
      end
   end

   // pins reused for other functions toggle every cycle
   always_ff @(posedge clk) begin
      toggle_ff <= ~toggle_ff;
   end

   assign extResetN = (lowCnt_ff == 3'h0);
   // straps steady before capture, both lines tied for disable
   assign dplusPin  = pinsFree ? toggle_ff : setDp;
   assign dminusPin = pinsFree ? ~toggle_ff : setDm;
   assign fixedPin  = pinsFree ? toggle_ff[2:0] : setFx;
   assign chargePin = pinsFree ? toggle_ff[3:1] : setCh;
   // reserved layout when the bench sets it, and every other cycle while pins are free
   assign layoutPin = pinsFree ? toggle_ff[1:0] : setLy;
endmodule : hscl_board_model
`default_nettype wire

/* testbench/hub_strap_config_latch_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "hscl_map.svh"

`define CHK(nm, ex, gt) begin checksDone++; if ((gt) !== (ex)) begin failCount++; \
   $display("[FAIL] %s exp=%h got=%h", nm, ex, gt); end end

module hub_strap_config_latch_tb;
   logic                clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata;
   logic                resetReq, pinsFree, extResetN;
   logic [5:0]          setDp, setDm, dpPin, dmPin;
   logic [2:0]          setFx, setCh, fxPin, chPin;
   logic [1:0]          setLy, lyPin;
   hscl_pkg::hscl_cfg_s hubCfg;
   logic [28:0]         funcPinAlt;
   int                  failCount, checksDone;

   hscl_board_model board_u (.clk(clk), .resetReq(resetReq), .pinsFree(pinsFree),
      .setDp(setDp), .setDm(setDm), .setFx(setFx), .setCh(setCh), .setLy(setLy),
      .extResetN(extResetN), .dplusPin(dpPin), .dminusPin(dmPin), .fixedPin(fxPin),
      .chargePin(chPin), .layoutPin(lyPin));

   hub_strap_config_latch dut_u (.clk(clk), .reset(reset), .en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .extResetN(extResetN),
      .portDplusDisableStrap(dpPin), .portDminusDisableStrap(dmPin),
      .fixedPortsSelectStrap(fxPin), .chargingPortsSelectStrap(chPin), .layoutStrap(lyPin),
      .hubCfg(hubCfg), .funcPinAlt(funcPinAlt));

   // core clock, derived on chip from the 25 MHz reference
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [5:0] pmask(input logic [2:0] c);
      case (c)
         3'h0: pmask = 6'h00;
         3'h1: pmask = 6'h01;
         3'h2: pmask = 6'h03;
         3'h3: pmask = 6'h07;
         3'h4: pmask = 6'h0f;
         3'h5: pmask = 6'h3f;
         default: pmask = 6'h00;
      endcase
   endfunction : pmask

   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // pready is read at the edge itself, before that edge updates it
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         failCount++;
         wrap_up;
      end
   endtask : apb

   task automatic wait_valid;
      int n;
      n = 0;
      while (hubCfg.valid !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      `CHK("validRise", 1'b1, hubCfg.valid);
   endtask : wait_valid

   task automatic check_cfg;
      logic [31:0] rd;
      logic        er;
      logic [5:0]  e;
      logic [31:0] st;
      e = setDp & setDm;
      st = {17'h0, setCh, 1'b0, setFx, 4'h0, (setFx > 3'h5) || (setCh > 3'h5),
            setLy[1], setLy == 2'h1, 1'b1};
      `CHK("u2Disable", e, hubCfg.u2Disable);
      `CHK("ssDisable", e, hubCfg.ssDisable);
      `CHK("fixedPorts", pmask(setFx), hubCfg.fixedPorts);
      `CHK("dcpPorts", pmask(setCh), hubCfg.dcpPorts);
      `CHK("cdpPorts", pmask(setCh), hubCfg.cdpPorts);
      `CHK("layout", setLy == 2'h1, hubCfg.layout);
      apb(1'b0, `HSCL_STATUS_OFS, 32'h0, rd, er);
      `CHK("status", st, rd);
      apb(1'b0, `HSCL_PORTS_OFS, 32'h0, rd, er);
      `CHK("ports", {10'h0, pmask(setCh), 2'h0, pmask(setFx), 2'h0, e}, rd);
      `CHK("funcPinAlt", (setLy == 2'h1) ? `HSCL_FUNC_ALT_MASK : 29'h0, funcPinAlt);
   endtask : check_cfg

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_apb;
      logic [31:0] rd;
      logic        er;
      apb(1'b0, `HSCL_CTRL_OFS, 32'h0, rd, er);
      `CHK("ctrlReset", 32'h0, rd);
      apb(1'b1, `HSCL_CTRL_OFS, 32'h3, rd, er);
      repeat (2) @(negedge clk);
      `CHK("ovrLayout2", `HSCL_FUNC_ALT_MASK, funcPinAlt);
      `CHK("layoutKept", setLy == 2'h1, hubCfg.layout);
      apb(1'b0, `HSCL_CTRL_OFS, 32'h0, rd, er);
      `CHK("ctrlBack", 32'h3, rd);
      apb(1'b1, `HSCL_CTRL_OFS, 32'h1, rd, er);
      repeat (2) @(negedge clk);
      `CHK("ovrLayout1", 29'h0, funcPinAlt);
      apb(1'b1, `HSCL_STATUS_OFS, 32'hffffffff, rd, er);
      apb(1'b1, `HSCL_CTRL_OFS, 32'h0, rd, er);
      apb(1'b0, 12'h00c, 32'h0, rd, er);
      `CHK("badRdErr", 1'b1, er);
      `CHK("badRdData", 32'h0, rd);
      apb(1'b1, 12'hffc, 32'h3, rd, er);
      `CHK("badWrErr", 1'b1, er);
      check_cfg;
   endtask : t_apb

   task automatic t_decode;
      hscl_pkg::hscl_cfg_s snap;
      int n;
      // codes 6 and reserved layouts included on purpose
      for (int c = 0; c < 7; c++) begin
         snap = hubCfg;
         @(posedge clk);
         setDp <= 6'h2b ^ 6'(c);
         setDm <= 6'h1d ^ {3'(c), 3'h0};
         setFx <= 3'(c);
         setCh <= 3'h6 - 3'(c);
         setLy <= 2'(c);
         resetReq <= 1'b1;
         @(posedge clk);
         resetReq <= 1'b0;
         n = 0;
         while (hubCfg.valid !== 1'b0 && n < 30) begin
            @(negedge clk);
            n++;
         end
         `CHK("validDrop", 1'b0, hubCfg.valid);
         `CHK("keptFields", snap[29:0], hubCfg[29:0]);
         wait_valid;
         check_cfg;
      end
   endtask : t_decode

   task automatic t_hold;
      hscl_pkg::hscl_cfg_s snap;
      snap = hubCfg;
      @(posedge clk);
      pinsFree <= 1'b1;
      repeat (30) @(negedge clk);
      `CHK("heldCfg", snap, hubCfg);
      @(posedge clk);
      pinsFree <= 1'b0;
   endtask : t_hold

   task automatic wrap_up;
      if (failCount == 0 && checksDone > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      reset = 1'b1;
      {psel, penable, pwrite, resetReq, pinsFree} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      setDp = 6'h3f;
      setDm = 6'h3f;
      setFx = 3'h5;
      setCh = 3'h5;
      setLy = 2'h1;
      failCount = 0;
      checksDone = 0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      wait_valid;
      check_cfg;
      t_apb;
      t_decode;
      t_hold;
      wrap_up;
   end

   // hang guard, well beyond the few hundred cycles the run needs
   initial begin
      repeat (5000) @(posedge clk);
      failCount++;
      wrap_up;
   end
endmodule : hub_strap_config_latch_tb
`default_nettype wire
